// ==== core/acs_sequencer.sv ====
// Purpose: Conversion sequencer and result registers of a 10-bit converter
// Assumes: APB slave with no wait states, pclk at 20 MHz
// Notes:   The analog core supplies its sample at the last converter tick
//
// What this block does
// R1 - Input above upper reference reads FFh high and 03h low, no overflow flag
// R2 - Input below lower reference reads zero in both result bytes
// R3 - Three-bit channel field value n selects analog input n
// R4 - Mode bit set means single conversion, clear means continuous
// R5 - Setting converter-on powers up and starts; done stays low meanwhile
// R6 - Writing the channel during a conversion aborts and restarts it
// R7 - Each completion while unlocked sets done and loads the 10-bit result
// R8 - Interrupt at completion only while interrupt enable is set
// R9 - Single mode clears converter-on by hardware at completion
// R10 - Software sets converter-on again for each further single conversion
// R11 - Continuous mode converts repeatedly without software action
// R12 - Continuous result stays valid until the next conversion finishes
// R13 - Reading the high byte clears done
// R14 - Reading the low byte locks both result registers
// R15 - Lock releases on high byte read or converter-on cleared
// R16 - While locked, continuous results do not reach the registers
// R17 - Software reads low then high byte; high alone is allowed
// R18 - Converter-on clear disables converter and stops conversion
// R19 - CPU wait has no effect; done interrupt can end it
// R20 - Halt disables converter; stabilisation time after wake-up
// R21 - High byte holds bits 9:2, low byte bits 1:0, rest zero
// R22 - Done is bit 7 and read-only; other bits writable; reset zero
// R23 - Conversion takes a fixed configurable count of converter ticks
// R24 - Completion while locked is discarded and sets no done
`timescale 1ns/1ns
module acs_sequencer #(
  parameter int ADDR_W = 8,
  parameter int CONV_CYC = acs_pkg::CONV_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire acs_pkg::acs_sample_t sample,
  input wire logic cpu_halt,
  output logic [2:0] conv_chan,
  output logic conv_power,
  output logic conv_start,
  output logic irq
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W out of range");
  end
  if (CONV_CYC < 1 || CONV_CYC > 65535) begin : g_bad_conv
    $error("CONV_CYC out of range");
  end

  localparam logic [acs_pkg::CNT_W-1:0] CONV_LAST = acs_pkg::CNT_W'(CONV_CYC - 1);
  localparam logic [acs_pkg::CNT_W-1:0] STAB_LAST =
    acs_pkg::CNT_W'(acs_pkg::STAB_CYC - 1);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_hit = (a == ADDR_W'(off));
  endfunction : addr_hit

  // Out-of-range inputs saturate; no overflow flag is kept
  function automatic logic [9:0] clamp(input acs_pkg::acs_sample_t s);
    if (s.over) begin
      clamp = acs_pkg::RES_FULL; // R1
    end else if (s.under) begin
      clamp = acs_pkg::RES_ZERO; // R2
    end else begin
      clamp = s.code;
    end
  endfunction : clamp

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic setup;
  logic access;
  logic hit_csr;
  logic hit_high;
  logic hit_low;
  logic csr_wr;
  logic high_rd;
  logic low_rd;
  acs_pkg::acs_csr_t wr_csr;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_csr = addr_hit(paddr, acs_pkg::CSR_OFF);
  assign hit_high = addr_hit(paddr, acs_pkg::HIGH_OFF);
  assign hit_low = addr_hit(paddr, acs_pkg::LOW_OFF);
  assign csr_wr = access && pwrite && hit_csr;
  assign high_rd = access && !pwrite && hit_high;
  assign low_rd = access && !pwrite && hit_low;
  assign wr_csr = acs_pkg::acs_csr_t'(pwdata[7:0]);
  assign pready = access;
  assign pslverr = access && !(hit_csr || hit_high || hit_low);

  // ----------------------------------------
  // State
  // ----------------------------------------
  acs_pkg::acs_csr_t csr_q;
  acs_pkg::acs_csr_t csr_d;
  logic [9:0] res_q;
  logic [9:0] res_d;
  logic lock_q;
  logic lock_d;
  logic halt_q;
  acs_pkg::acs_state_t state_q;
  acs_pkg::acs_state_t state_d;
  logic [acs_pkg::CNT_W-1:0] cnt_q;
  logic [acs_pkg::CNT_W-1:0] cnt_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic on_now;
  logic tick;
  logic done_evt;
  logic take_res;

  // A fresh write counts at once, so a write clearing converter-on stops at once without a restart pulse
  assign on_now = csr_wr ? wr_csr.converter_on : csr_q.converter_on;
  assign take_res = done_evt && !lock_q; // R16 R24

  acs_rate_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_q == acs_pkg::ACS_CONV),
    .div4(csr_q.speed),
    .tick(tick)
  );

  // ----------------------------------------
  // Conversion sequence
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    conv_start = 1'b0;
    done_evt = 1'b0;
    if (cpu_halt) begin
      state_d = acs_pkg::ACS_IDLE; // R20
    end else if (halt_q) begin
      state_d = acs_pkg::ACS_STAB; // R20
      cnt_d = '0;
    end else begin
      case (state_q)
        acs_pkg::ACS_IDLE: begin
          if (on_now) begin
            state_d = acs_pkg::ACS_CONV; // R5
            cnt_d = '0;
            conv_start = 1'b1;
          end
        end
        acs_pkg::ACS_STAB: begin
          // Results before the analog core settles would be inaccurate
          if (cnt_q == STAB_LAST) begin
            state_d = acs_pkg::ACS_IDLE; // R20
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        acs_pkg::ACS_CONV: begin
          if (!on_now) begin
            state_d = acs_pkg::ACS_IDLE; // R18
          end else if (csr_wr) begin
            cnt_d = '0; // R6
            conv_start = 1'b1;
          end else if (tick) begin
            if (cnt_q == CONV_LAST) begin
              done_evt = 1'b1; // R23
              if (csr_q.oneshot) begin
                state_d = acs_pkg::ACS_IDLE; // R4
              end else begin
                cnt_d = '0; // R11
                conv_start = 1'b1;
              end
            end else begin
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        default: begin
          state_d = acs_pkg::ACS_IDLE;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= acs_pkg::ACS_IDLE;
      cnt_q <= '0;
      halt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      halt_q <= cpu_halt;
    end
  end

  // ----------------------------------------
  // Control, result and lock
  // ----------------------------------------
  always_comb begin
    csr_d = csr_q;
    res_d = res_q;
    lock_d = lock_q;
    if (csr_wr) begin
      csr_d = wr_csr;
      csr_d.done = csr_q.done; // R22
    end else if (done_evt && csr_q.oneshot) begin
      csr_d.converter_on = 1'b0; // R9
    end
    if (high_rd) begin
      csr_d.done = 1'b0; // R13
    end
    if (take_res) begin
      csr_d.done = 1'b1; // R7
      res_d = clamp(sample); // R12
    end
    if (low_rd) begin
      lock_d = 1'b1; // R14
    end
    if (high_rd || (csr_q.converter_on && !csr_d.converter_on)) begin
      lock_d = 1'b0; // R15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_q <= acs_pkg::acs_csr_t'(acs_pkg::CSR_RST);
      res_q <= acs_pkg::RES_RST;
      lock_q <= 1'b0;
    end else begin
      csr_q <= csr_d;
      res_q <= res_d;
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Captured in the setup cycle so the access phase needs no wait state
  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (hit_csr) begin
        prdata_d[7:0] = csr_q;
      end else if (hit_high) begin
        prdata_d[7:0] = res_q[9:2]; // R21
      end else if (hit_low) begin
        prdata_d[1:0] = res_q[1:0]; // R21
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // Outputs to the analog core and CPU
  // ----------------------------------------
  assign prdata = prdata_q;
  assign conv_chan = csr_q.chan; // R3
  assign conv_power = csr_q.converter_on && !cpu_halt; // R18
  // Level output, so it also releases a waiting CPU
  assign irq = csr_q.done && csr_q.done_irq_enable; // R8 R19

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_clamp_full: assert property (@(posedge pclk) disable iff (!presetn)
    take_res && sample.over |=> res_q == 10'h3FF) // R1
    else $error("over-range result not saturated");

  a_clamp_zero: assert property (@(posedge pclk) disable iff (!presetn)
    take_res && sample.under && !sample.over |=> res_q == 10'h000) // R2
    else $error("under-range result not zero");

  a_chan_out: assert property (@(posedge pclk) disable iff (!presetn)
    csr_wr |=> conv_chan == $past(pwdata[2:0])) // R3
    else $error("channel output does not follow write");

  a_start_on: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == acs_pkg::ACS_IDLE && csr_wr && wr_csr.converter_on && !cpu_halt && !halt_q
    |-> conv_start ##1 state_q == acs_pkg::ACS_CONV) // R5
    else $error("converter-on did not start a conversion");

  a_chan_restart: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == acs_pkg::ACS_CONV && csr_wr && wr_csr.converter_on && !cpu_halt && !halt_q
    |-> conv_start ##1 cnt_q == '0) // R6
    else $error("channel write did not restart");

  a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
    take_res |=> csr_q.done && irq == csr_q.done_irq_enable) // R7 R8
    else $error("completion did not set done");

  a_oneshot_off: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && csr_q.oneshot && !csr_wr |=> !csr_q.converter_on) // R9
    else $error("single mode left converter on");

  a_cont_rerun: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && !csr_q.oneshot && !csr_wr && !cpu_halt |-> conv_start) // R11
    else $error("continuous mode did not restart");

  a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
    high_rd && !take_res |=> !csr_q.done) // R13
    else $error("high byte read did not clear done");

  a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    lock_q |=> $stable(res_q)) // R14 R16
    else $error("locked result changed");

  a_lock_free: assert property (@(posedge pclk) disable iff (!presetn)
    high_rd |=> !lock_q) // R15
    else $error("lock held after high byte read");

  a_off_power: assert property (@(posedge pclk) disable iff (!presetn)
    !csr_q.converter_on || cpu_halt |-> !conv_power) // R18 R20
    else $error("converter powered while off or halted");

  a_halt_stab: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_halt) |=> state_q == acs_pkg::ACS_STAB ##1 !conv_start) // R20
    else $error("no stabilisation after halt");

  a_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && hit_low |=> prdata[31:2] == 30'h0) // R21
    else $error("low byte upper bits not zero");

  a_done_ro: assert property (@(posedge pclk) disable iff (!presetn)
    csr_wr && !take_res && !high_rd |=> csr_q.done == $past(csr_q.done)) // R22
    else $error("software changed done");

  a_drop_locked: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && lock_q && !high_rd |=> csr_q.done == $past(csr_q.done) && $stable(res_q)) // R24
    else $error("locked completion changed done or result");

  c_oneshot: cover property (@(posedge pclk) disable iff (!presetn)
    done_evt && csr_q.oneshot);
  c_cont_two: cover property (@(posedge pclk) disable iff (!presetn)
    done_evt && !csr_q.oneshot ##[1:200] done_evt);
  c_locked_drop: cover property (@(posedge pclk) disable iff (!presetn)
    done_evt && lock_q);
  c_halt_wake: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_halt) ##[1:40] conv_start);

endmodule : acs_sequencer

// ==== core/acs_pkg.sv ====
// Purpose: Shared constants and types for the converter sequencer
// Assumes: 20 MHz pclk, APB register access, one 32-bit word per register
// Notes:   Result is 10 bits, split over a high and a low byte register
package acs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CSR_OFF = 8'h00;
  localparam logic [7:0] HIGH_OFF = 8'h04;
  localparam logic [7:0] LOW_OFF = 8'h08;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [9:0] RES_RST = 10'h000;
  localparam logic [9:0] RES_FULL = 10'h3FF;
  localparam logic [9:0] RES_ZERO = 10'h000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC = 14;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_STAB,
    ACS_CONV
  } acs_state_t;

  typedef struct packed {
    logic done;
    logic speed;
    logic converter_on;
    logic done_irq_enable;
    logic oneshot;
    logic [2:0] chan;
  } acs_csr_t;

  typedef struct packed {
    logic over;
    logic under;
    logic [9:0] code;
  } acs_sample_t;

endpackage : acs_pkg

// ==== core/acs_rate_div.sv ====
// Purpose: Converter clock enable, pclk/2 or pclk/4
// Assumes: One clock domain, enable is a one-cycle pulse
// Notes:   Rate changes take effect at once, without restarting the counter
`timescale 1ns/1ns
module acs_rate_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic div4,
  output logic tick
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    cnt_d = cnt_q + 2'h1;
    if (!run) begin
      cnt_d = 2'h0;
    end else if (!div4 && cnt_q[0]) begin
      cnt_d = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Tick on the last count so a fresh start waits one full period
  assign tick = run && (div4 ? (cnt_q == 2'h3) : (cnt_q == 2'h1));

endmodule : acs_rate_div

// ==== tb/acs_analog_model.sv ====
// Purpose: Behavioural analog multiplexer and converter core for the bench
// Assumes: Result follows the selected channel plus a level set by the bench
// Notes:   Channel 7 reads over range, channel 6 under range
`timescale 1ns/1ns
module acs_analog_model (
  input wire logic pclk,
  input wire logic [2:0] conv_chan,
  input wire logic conv_power,
  input wire logic [9:0] level,
  output acs_pkg::acs_sample_t sample
);
  // ----------------------------------------
  // Sample path
  // ----------------------------------------
  initial sample = '0;
  // Unpowered core shows a pattern that flips each cycle, never a steady result
  always @(posedge pclk) begin
    if (conv_power) begin
      sample <= '{over: conv_chan == 3'h7, under: conv_chan == 3'h6,
                  code: level + 10'(conv_chan)};
    end else begin
      sample <= ~sample;
    end
  end
endmodule : acs_analog_model

// ==== tb/acs_sequencer_test.sv ====
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Zero-wait APB slave, conversions shortened through CONV_CYC
// Notes:   One-shot cases come from a table, odd cases are written out
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module acs_sequencer_test;
  localparam int CONV = 4;
  localparam logic [7:0] CSR = acs_pkg::CSR_OFF;
  localparam logic [7:0] HI = acs_pkg::HIGH_OFF;
  localparam logic [7:0] LO = acs_pkg::LOW_OFF;
  typedef struct packed {
    logic [2:0] chan;
    logic speed;
    logic irq_en;
    logic [9:0] level;
    logic [7:0] hi;
    logic [1:0] lo;
  } acs_row_t;
  acs_row_t rows [8] = '{
    '{3'h0, 1'b0, 1'b1, 10'h000, 8'h00, 2'h0}, '{3'h1, 1'b1, 1'b0, 10'h2FE, 8'hBF, 2'h3},
    '{3'h2, 1'b0, 1'b1, 10'h3FD, 8'hFF, 2'h3}, '{3'h3, 1'b1, 1'b0, 10'h0FD, 8'h40, 2'h0},
    '{3'h4, 1'b0, 1'b1, 10'h1A0, 8'h69, 2'h0}, '{3'h5, 1'b0, 1'b0, 10'h001, 8'h01, 2'h2},
    '{3'h6, 1'b1, 1'b1, 10'h155, 8'h00, 2'h0}, '{3'h7, 1'b0, 1'b0, 10'h000, 8'hFF, 2'h3}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cpu_halt = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] level = 10'h000;
  logic [31:0] prdata, rd, wd;
  logic pready, pslverr, conv_power, conv_start, irq, err;
  logic [2:0] conv_chan;
  acs_pkg::acs_sample_t sample;
  int miscompares = 0, checked = 0, cycles = 0, starts = 0, s0;

  acs_sequencer #(.ADDR_W(8), .CONV_CYC(CONV)) acs_sequencer_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .cpu_halt(cpu_halt), .conv_chan(conv_chan), .conv_power(conv_power),
    .conv_start(conv_start), .irq(irq));
  acs_analog_model acs_analog_model_i (.pclk(pclk), .conv_chan(conv_chan),
    .conv_power(conv_power), .level(level), .sample(sample));

  always #25 pclk = ~pclk;
  // Start pulses are counted so aborts and auto restarts can be seen
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1) starts <= starts + 1;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends in the first access cycle, where pready is already high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_expect(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_expect

  // Polls the control word; the design never stalls the bus
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, CSR, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 100);
    `CHK(rd[7], 1'b1)
  endtask : wait_done

  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_expect(CSR, 32'h0);
    foreach (rows[i]) begin
      level <= rows[i].level;
      wd = {24'h0, 1'b0, rows[i].speed, 1'b1, rows[i].irq_en, 1'b1, rows[i].chan};
      apb(1'b1, CSR, wd);
      @(negedge pclk);
      `CHK(conv_chan, rows[i].chan)
      `CHK(conv_power, 1'b1)
      rd_expect(CSR, wd);
      wait_done();
      `CHK(rd, wd ^ 32'hA0)
      @(negedge pclk);
      `CHK(irq, rows[i].irq_en)
      rd_expect(LO, {30'h0, rows[i].lo});
      rd_expect(HI, {24'h0, rows[i].hi});
      rd_expect(CSR, wd ^ 32'h20);
    end
    // Unmapped place, the read-only high word and the read-only done bit
    apb(1'b1, 8'h0C, 32'hFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, HI, 32'h12);
    rd_expect(HI, 32'hFF);
    apb(1'b1, CSR, 32'h80);
    rd_expect(CSR, 32'h0);
    // Channel rewrite mid conversion in single mode
    s0 = starts;
    apb(1'b1, CSR, 32'h29);
    apb(1'b1, CSR, 32'h2A);
    wait_done();
    rd_expect(LO, 32'h2);
    rd_expect(HI, 32'h0);
    `CHK(starts - s0, 2)
    // Continuous mode with the result lock held
    level <= 10'h100;
    apb(1'b1, CSR, 32'h21);
    wait_done();
    rd_expect(LO, 32'h1);
    level <= 10'h200;
    repeat (4 * (2 * CONV + 2)) @(posedge pclk);
    rd_expect(CSR, 32'hA1);
    rd_expect(HI, 32'h40);
    wait_done();
    rd_expect(LO, 32'h1);
    rd_expect(HI, 32'h80);
    // Lock released by switching off, and the converter stops
    wait_done();
    rd_expect(LO, 32'h1);
    apb(1'b1, CSR, 32'h01);
    @(negedge pclk);
    `CHK(conv_power, 1'b0)
    s0 = starts;
    repeat (30) @(posedge pclk);
    `CHK(starts, s0)
    rd_expect(CSR, 32'h81);
    rd_expect(HI, 32'h80);
    level <= 10'h302;
    apb(1'b1, CSR, 32'h21);
    wait_done();
    rd_expect(LO, 32'h3);
    // Halt stops conversion, restart only after the settling time
    cpu_halt <= 1'b1;
    @(negedge pclk);
    `CHK(conv_power, 1'b0)
    rd_expect(HI, 32'hC0);
    s0 = starts;
    repeat (30) @(posedge pclk);
    `CHK(starts, s0)
    cpu_halt <= 1'b0;
    repeat (acs_pkg::STAB_CYC - 2) @(posedge pclk);
    `CHK(starts, s0)
    wait_done();
    `CHK(rd[5], 1'b1)
    // Reset in mid run clears everything
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    `CHK({conv_power, irq, pready}, 3'b000)
    @(posedge pclk);
    presetn <= 1'b1;
    rd_expect(CSR, 32'h0);
    rd_expect(HI, 32'h0);
    rd_expect(LO, 32'h0);
    tally_and_finish();
  end
endmodule : acs_sequencer_test
